// file: rtl/fqs_host.sv
// host-side sequencer for query, identification and security modes
`timescale 1ns/1ns
`default_nettype none
module fqs_host (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      cmd_valid,
  input  wire fqs_pkg::fqs_op_t          cmd_op,
  input  wire logic [fqs_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [fqs_pkg::DATA_W-1:0] cmd_data,
  input  wire logic                      boot_protect,
  output logic                           cmd_ready,
  output logic                           rsp_valid,
  output logic                           rsp_err,
  output logic [fqs_pkg::DATA_W-1:0]     rsp_data,
  output fqs_pkg::fqs_mode_t             mode,
  output logic                           user_locked,
  output logic                           ce_n,
  output logic                           oe_n,
  output logic                           we_n,
  output logic [fqs_pkg::ADDR_W-1:0]     addr,
  output logic [fqs_pkg::DATA_W-1:0]     data_out,
  output logic                           data_oe,
  input  wire logic [fqs_pkg::DATA_W-1:0] data_in,
  output logic                           wp_n,
  output logic                           flash_rst_n,
  input  wire logic                      ready_busy_n
);
  import fqs_pkg::*;

  // all sequencer state
  typedef struct packed {
    fqs_state_t        st;       // sequencer state
    fqs_mode_t         mode;     // believed device mode
    logic              locked;   // user segment lock issued
    fqs_op_t           op;       // operation in flight
    logic [2:0]        step;     // write index in sequence
    logic [ADDR_W-1:0] a;        // target address
    logic [DATA_W-1:0] d;        // target data
    logic [15:0]       cnt;      // wait counter
    logic              tog;      // toggle bit of previous read
    logic              bstart;   // bus cycle request
    logic              brd;      // bus cycle is a read
    logic [ADDR_W-1:0] ba;       // bus cycle address
    logic [DATA_W-1:0] bd;       // bus cycle data
    logic              ready;    // command port ready
    logic              rvalid;   // answer pulse
    logic              rerr;     // answer refused
    logic [DATA_W-1:0] rdata;    // answer word
    logic              wp_n;     // boot guard pin
    logic              rst_n;    // device reset pin
  } fqs_host_t;

  fqs_host_t r_r;
  fqs_host_t r_nxt;

  logic [DATA_W-1:0] bus_rdata; // word from the last read cycle
  logic              bus_done;  // bus cycle finished
  logic [ADDR_W-1:0] tgt;       // decoded program/erase target
  logic              refuse;    // command may not be issued
  logic [36:0]       sw;        // {last, addr, data} of current write

  // base of a block in the top-boot map
  function automatic logic [ADDR_W-1:0] blk_base(input logic [5:0] n);
    logic [ADDR_W-1:0] b;
    b = {n[4:0], 15'h0000};
    if (n == BLK_TOP) begin
      b = BLK_TOP_A;
    end else if (n == BLK_4K_HI) begin
      b = BLK_4K_HI_A;
    end else if (n == BLK_4K_LO) begin
      b = BLK_4K_LO_A;
    end else if (n == BLK_16K) begin
      b = BLK_16K_A;
    end
    return b;
  endfunction

  // write number idx of the sequence for op: {last, address, data}
  function automatic logic [36:0] seq_word(input fqs_op_t op,
      input logic [2:0] idx, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    logic [15:0] c;
    logic        erase;
    erase = (op == OP_SECTOR_ERASE) || (op == OP_BLOCK_ERASE);
    case (op)
      OP_QUERY_ENTER:  c = CMD_QUERY;
      OP_ID_ENTER:     c = CMD_ID;
      OP_SEC_ENTER:    c = CMD_SEC;
      OP_PROGRAM:      c = CMD_PROG;
      OP_SEC_PROGRAM:  c = CMD_SEC_PROG;
      OP_SEC_LOCK:     c = CMD_SEC_LOCK;
      OP_SECTOR_ERASE: c = CMD_ERASE;
      OP_BLOCK_ERASE:  c = CMD_ERASE;
      default:         c = CMD_EXIT;
    endcase
    if (op == OP_QUERY_SHORT) begin
      return {1'b1, QUERY_SHORT_ADDR, QUERY_SHORT_DATA};
    end
    case (idx)
      3'h0: return {1'b0, UNLOCK1_ADDR, UNLOCK1_DATA};
      3'h1: return {1'b0, UNLOCK2_ADDR, UNLOCK2_DATA};
      3'h2: return {~(erase || op == OP_PROGRAM || op == OP_SEC_PROGRAM
                      || op == OP_SEC_LOCK), UNLOCK1_ADDR, c};
      3'h3: begin
        if (op == OP_SEC_LOCK) begin
          return {1'b1, a, LOCK_DATA};
        end else if (erase) begin
          return {1'b0, UNLOCK1_ADDR, UNLOCK1_DATA};
        end
        return {1'b1, a, d};
      end
      3'h4: return {1'b0, UNLOCK2_ADDR, UNLOCK2_DATA};
      default: return {1'b1, a,
                       (op == OP_BLOCK_ERASE) ? CMD_BLOCK : CMD_SECTOR};
    endcase
  endfunction

  fqs_bus_cycle u_bus (
    .clk      (clk),
    .reset    (reset),
    .start    (r_r.bstart),
    .is_read  (r_r.brd),
    .addr     (r_r.ba),
    .wdata    (r_r.bd),
    .data_in  (data_in),
    .ce_n     (ce_n),
    .oe_n     (oe_n),
    .we_n     (we_n),
    .addr_out (addr),
    .data_out (data_out),
    .data_oe  (data_oe),
    .rdata    (bus_rdata),
    .done     (bus_done)
  );

  // target decode and admission checks for a new command
  always_comb begin
    tgt = cmd_addr;
    if (cmd_op == OP_SECTOR_ERASE) begin
      tgt = {cmd_addr[ADDR_W-1:SECTOR_LSB], 11'h000};
    end else if (cmd_op == OP_BLOCK_ERASE) begin
      tgt = blk_base(cmd_addr[5:0]);
    end
    refuse = 1'b0;
    case (cmd_op)
      OP_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE: begin
        // array changes only from read mode and outside a guarded boot block
        refuse = (r_r.mode != MODE_READ)
              || (!r_r.wp_n && tgt >= BOOT_BASE)
              || (cmd_op == OP_BLOCK_ERASE && cmd_addr[5:0] > BLK_TOP);
      end
      OP_SEC_PROGRAM, OP_SEC_LOCK: begin
        refuse = (r_r.mode != MODE_READ) || r_r.locked;
      end
      OP_QUERY_ENTER, OP_QUERY_SHORT, OP_ID_ENTER, OP_SEC_ENTER: begin
        // modes do not nest; leave the current one first
        refuse = (r_r.mode != MODE_READ);
      end
      default: refuse = 1'b0; // reads, exit and reset always allowed
    endcase
  end

  assign sw = seq_word(r_r.op, r_r.step, r_r.a, r_r.d);

  // sequencer next state
  always_comb begin
    r_nxt        = r_r;
    r_nxt.bstart = 1'b0;
    r_nxt.rvalid = 1'b0;
    r_nxt.wp_n   = ~boot_protect;
    case (r_r.st)
      ST_RESET: begin
        // hold the device reset pin low, then let it recover
        r_nxt.rst_n = 1'b0;
        if (r_r.cnt == 16'(RST_LOW_CYC - 1)) begin
          r_nxt.st    = ST_RECOVER;
          r_nxt.cnt   = 16'h0000;
          r_nxt.rst_n = 1'b1;
        end else begin
          r_nxt.cnt = r_r.cnt + 16'h0001;
        end
      end
      ST_RECOVER: begin
        if (r_r.cnt == 16'(RST_REC_CYC - 1)) begin
          r_nxt.st   = ST_DONE;
          r_nxt.mode = MODE_READ;
        end else begin
          r_nxt.cnt = r_r.cnt + 16'h0001;
        end
      end
      ST_IDLE: begin
        if (cmd_valid) begin
          r_nxt.op    = cmd_op;
          r_nxt.a     = tgt;
          r_nxt.d     = cmd_data;
          r_nxt.step  = 3'h0;
          r_nxt.cnt   = 16'h0000;
          r_nxt.rdata = '0;
          r_nxt.rerr  = refuse;
          if (refuse) begin
            r_nxt.st = ST_DONE;
          end else if (cmd_op == OP_HW_RESET) begin
            r_nxt.st = ST_RESET;
          end else if (cmd_op == OP_READ) begin
            // in a table mode the read returns that table
            r_nxt.bstart = 1'b1;
            r_nxt.brd    = 1'b1;
            r_nxt.ba     = cmd_addr;
            r_nxt.st     = ST_RD_WAIT;
          end else if (cmd_op == OP_EXIT) begin
            r_nxt.st = ST_PRE_RDY;
          end else begin
            r_nxt.st = ST_WRITE;
          end
        end
      end
      ST_PRE_RDY: begin
        // an exit while busy would be ignored; wait for ready
        if (ready_busy_n) begin
          r_nxt.st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        r_nxt.bstart = 1'b1;
        r_nxt.brd    = 1'b0;
        r_nxt.ba     = sw[35:16];
        r_nxt.bd     = sw[15:0];
        r_nxt.st     = ST_WR_WAIT;
      end
      ST_WR_WAIT: begin
        if (bus_done) begin
          if (!sw[36]) begin
            r_nxt.step = r_r.step + 3'h1;
            r_nxt.st   = ST_WRITE;
          end else begin
            r_nxt.st = ST_DONE;
            case (r_r.op)
              OP_QUERY_ENTER, OP_QUERY_SHORT: r_nxt.mode = MODE_QUERY;
              OP_ID_ENTER:  r_nxt.mode = MODE_ID;
              OP_SEC_ENTER: r_nxt.mode = MODE_SEC;
              // one exit leaves any mode and clears upsets
              OP_EXIT:      r_nxt.mode = MODE_READ;
              OP_SEC_PROGRAM: r_nxt.st = ST_TOG1;
              OP_SEC_LOCK: begin
                r_nxt.locked = 1'b1;
                r_nxt.st     = ST_BUSY;
              end
              default: r_nxt.st = ST_BUSY;
            endcase
          end
        end
      end
      ST_BUSY: begin
        // busy pin is valid only a while after the last strobe
        if (r_r.cnt < 16'(BUSY_VAL_CYC)) begin
          r_nxt.cnt = r_r.cnt + 16'h0001;
        end else if (ready_busy_n) begin
          r_nxt.st = ST_DONE;
        end
      end
      ST_TOG1, ST_TOG2: begin
        // complemented-bit polling is not valid here, so compare toggles
        if (!r_r.brd || bus_done) begin
          r_nxt.bstart = 1'b1;
          r_nxt.brd    = 1'b1;
          r_nxt.ba     = r_r.a;
          if (bus_done) begin
            r_nxt.st  = ST_TOG2;
            r_nxt.tog = bus_rdata[TOGGLE_BIT];
            if (r_r.st == ST_TOG2 && bus_rdata[TOGGLE_BIT] == r_r.tog) begin
              r_nxt.bstart = 1'b0;
              r_nxt.st     = ST_DONE;
            end
          end
        end
      end
      ST_RD_WAIT: begin
        if (bus_done) begin
          r_nxt.rdata = bus_rdata;
          r_nxt.st    = ST_DONE;
        end
      end
      ST_DONE: begin
        r_nxt.rvalid = 1'b1;
        r_nxt.st     = ST_IDLE;
      end
      default: begin
        r_nxt.st = ST_IDLE;
      end
    endcase
    r_nxt.ready = (r_nxt.st == ST_IDLE);
  end

  // state register; reset pulses the device reset pin first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_r <= '{st: ST_RESET, mode: MODE_READ, op: OP_READ, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign cmd_ready   = r_r.ready;
  assign rsp_valid   = r_r.rvalid;
  assign rsp_err     = r_r.rerr;
  assign rsp_data    = r_r.rdata;
  assign mode        = r_r.mode;
  assign user_locked = r_r.locked;
  assign wp_n        = r_r.wp_n;
  assign flash_rst_n = r_r.rst_n;
endmodule
`default_nettype wire

// file: rtl/fqs_pkg.sv
// shared constants and types of the flash mode controller
package fqs_pkg;

  // pin widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // unlock and command words
  localparam logic [19:0] UNLOCK1_ADDR     = 20'h00555;
  localparam logic [15:0] UNLOCK1_DATA     = 16'h00aa;
  localparam logic [19:0] UNLOCK2_ADDR     = 20'h002aa;
  localparam logic [15:0] UNLOCK2_DATA     = 16'h0055;
  localparam logic [15:0] CMD_QUERY        = 16'h0098;
  localparam logic [15:0] CMD_ID           = 16'h0090;
  localparam logic [15:0] CMD_SEC          = 16'h0088;
  localparam logic [15:0] CMD_EXIT         = 16'h00f0;
  localparam logic [15:0] CMD_PROG         = 16'h00a0;
  localparam logic [15:0] CMD_SEC_PROG     = 16'h00a5;
  localparam logic [15:0] CMD_SEC_LOCK     = 16'h0085;
  localparam logic [15:0] CMD_ERASE        = 16'h0080;
  localparam logic [15:0] CMD_SECTOR       = 16'h0050;
  localparam logic [15:0] CMD_BLOCK        = 16'h0030;
  localparam logic [15:0] LOCK_DATA        = 16'h0000;
  localparam logic [19:0] QUERY_SHORT_ADDR = 20'h00055;
  localparam logic [15:0] QUERY_SHORT_DATA = 16'h0089;

  // address fields and the data toggle bit
  localparam int SECTOR_LSB = 11;
  localparam int BLOCK_LSB  = 15;
  localparam int TOGGLE_BIT = 6;

  // top-boot block map
  localparam logic [5:0]  BLK_TOP     = 6'h22;
  localparam logic [5:0]  BLK_4K_HI   = 6'h21;
  localparam logic [5:0]  BLK_4K_LO   = 6'h20;
  localparam logic [5:0]  BLK_16K     = 6'h1f;
  localparam logic [19:0] BLK_TOP_A   = 20'hfe000;
  localparam logic [19:0] BLK_4K_HI_A = 20'hfd000;
  localparam logic [19:0] BLK_4K_LO_A = 20'hfc000;
  localparam logic [19:0] BLK_16K_A   = 20'hf8000;
  localparam logic [19:0] BOOT_BASE   = 20'hfe000;

  // timing, in ns, and derived cycle counts
  localparam int CLK_NS        = 10;
  localparam int WE_LOW_NS     = 40;
  localparam int RD_ACCESS_NS  = 80;
  localparam int RST_LOW_NS    = 500;
  localparam int RST_REC_NS    = 50;
  localparam int BUSY_VALID_NS = 100;
  localparam int WE_LOW_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_LOW_CYC   = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_REC_CYC   = (RST_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_VAL_CYC  = (BUSY_VALID_NS + CLK_NS - 1) / CLK_NS;

  // user operations
  typedef enum logic [3:0] {
    OP_READ         = 4'h0,
    OP_QUERY_ENTER  = 4'h1,
    OP_QUERY_SHORT  = 4'h2,
    OP_ID_ENTER     = 4'h3,
    OP_SEC_ENTER    = 4'h4,
    OP_EXIT         = 4'h5,
    OP_PROGRAM      = 4'h6,
    OP_SEC_PROGRAM  = 4'h7,
    OP_SEC_LOCK     = 4'h8,
    OP_SECTOR_ERASE = 4'h9,
    OP_BLOCK_ERASE  = 4'ha,
    OP_HW_RESET     = 4'hb
  } fqs_op_t;

  // mode the device is believed to be in
  typedef enum logic [1:0] {
    MODE_READ  = 2'h0,
    MODE_QUERY = 2'h1,
    MODE_ID    = 2'h2,
    MODE_SEC   = 2'h3
  } fqs_mode_t;

  // main sequencer states
  typedef enum logic [10:0] {
    ST_RESET   = 11'h001,
    ST_RECOVER = 11'h002,
    ST_IDLE    = 11'h004,
    ST_PRE_RDY = 11'h008,
    ST_WRITE   = 11'h010,
    ST_WR_WAIT = 11'h020,
    ST_RD_WAIT = 11'h040,
    ST_BUSY    = 11'h080,
    ST_TOG1    = 11'h100,
    ST_TOG2    = 11'h200,
    ST_DONE    = 11'h400
  } fqs_state_t;

  // bus cycle states
  typedef enum logic [3:0] {
    B_IDLE   = 4'h1,
    B_SETUP  = 4'h2,
    B_STROBE = 4'h4,
    B_HOLD   = 4'h8
  } fqs_bstate_t;

endpackage

// file: rtl/fqs_bus_cycle.sv
// one asynchronous flash bus cycle (read or write) on the pins
`timescale 1ns/1ns
`default_nettype none
module fqs_bus_cycle #(
  parameter int WE_CYC = fqs_pkg::WE_LOW_CYC,
  parameter int RD_CYC = fqs_pkg::RD_ACCESS_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      start,
  input  wire logic                      is_read,
  input  wire logic [fqs_pkg::ADDR_W-1:0] addr,
  input  wire logic [fqs_pkg::DATA_W-1:0] wdata,
  input  wire logic [fqs_pkg::DATA_W-1:0] data_in,
  output logic                           ce_n,
  output logic                           oe_n,
  output logic                           we_n,
  output logic [fqs_pkg::ADDR_W-1:0]     addr_out,
  output logic [fqs_pkg::DATA_W-1:0]     data_out,
  output logic                           data_oe,
  output logic [fqs_pkg::DATA_W-1:0]     rdata,
  output logic                           done
);
  import fqs_pkg::*;

  // counter is 8 bits wide
  if (WE_CYC < 1 || WE_CYC > 255 || RD_CYC < 1 || RD_CYC > 255) begin : g_chk
    $error("strobe counts must lie in 1..255");
  end

  // all state of the cycle engine
  typedef struct packed {
    fqs_bstate_t       st;    // phase
    logic [7:0]        cnt;   // strobe cycles left
    logic              rd;    // current cycle is a read
    logic              ce_n;  // chip select pin
    logic              oe_n;  // output gate pin
    logic              we_n;  // write strobe pin
    logic [ADDR_W-1:0] a;     // address pins
    logic [DATA_W-1:0] d;     // write data
    logic              doe;   // drive data pins
    logic [DATA_W-1:0] rd_d;  // captured read word
    logic              done;  // end of cycle pulse
  } fqs_bus_t;

  fqs_bus_t r_r;
  fqs_bus_t r_nxt;

  // next-state logic
  always_comb begin
    r_nxt      = r_r;
    r_nxt.done = 1'b0;
    case (r_r.st)
      B_IDLE: begin
        if (start) begin
          // address and select first, strobe a cycle later
          r_nxt.st   = B_SETUP;
          r_nxt.rd   = is_read;
          r_nxt.a    = addr;
          r_nxt.d    = wdata;
          r_nxt.ce_n = 1'b0;
          // data only driven while the output gate is high
          r_nxt.doe  = ~is_read;
        end
      end
      B_SETUP: begin
        r_nxt.st = B_STROBE;
        if (r_r.rd) begin
          r_nxt.oe_n = 1'b0;
          r_nxt.cnt  = 8'(RD_CYC - 1);
        end else begin
          r_nxt.we_n = 1'b0;
          r_nxt.cnt  = 8'(WE_CYC - 1);
        end
      end
      B_STROBE: begin
        if (r_r.cnt == 8'h00) begin
          r_nxt.st   = B_HOLD;
          r_nxt.oe_n = 1'b1;
          r_nxt.we_n = 1'b1;
          // access time has elapsed, word is stable now
          if (r_r.rd) begin
            r_nxt.rd_d = data_in;
          end
        end else begin
          r_nxt.cnt = r_r.cnt - 8'h01;
        end
      end
      B_HOLD: begin
        // address and data held one cycle past the strobe edge
        r_nxt.st   = B_IDLE;
        r_nxt.ce_n = 1'b1;
        r_nxt.doe  = 1'b0;
        r_nxt.done = 1'b1;
      end
      default: begin
        r_nxt.st = B_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_r <= '{st: B_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign ce_n     = r_r.ce_n;
  assign oe_n     = r_r.oe_n;
  assign we_n     = r_r.we_n;
  assign addr_out = r_r.a;
  assign data_out = r_r.d;
  assign data_oe  = r_r.doe;
  assign rdata    = r_r.rd_d;
  assign done     = r_r.done;
endmodule
`default_nettype wire

// file: bench/fqs_props.sv
// pin and handshake properties of the flash mode controller
`timescale 1ns/1ns
`default_nettype none
module fqs_props
  import fqs_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic                       boot_protect,
  input wire logic                       cmd_ready,
  input wire logic                       rsp_valid,
  input wire logic                       rsp_err,
  input wire fqs_pkg::fqs_mode_t         mode,
  input wire logic                       user_locked,
  input wire logic                       ce_n,
  input wire logic                       oe_n,
  input wire logic                       we_n,
  input wire logic [fqs_pkg::ADDR_W-1:0] addr,
  input wire logic [fqs_pkg::DATA_W-1:0] data_out,
  input wire logic                       data_oe,
  input wire logic                       wp_n,
  input wire logic                       flash_rst_n,
  input wire logic                       ready_busy_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] low_cnt_r; // edges seen with the reset pin low
  // counts the reset pulse; saturates so a long hold never wraps
  always_ff @(posedge clk or posedge reset) begin
    if (reset || flash_rst_n) low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hff) low_cnt_r <= low_cnt_r + 8'h01;
  end
  // strobe low, address and data stable, four cycles
  sequence we_low_s;
    (!we_n && $stable(addr) && $stable(data_out)) [*4];
  endsequence
  write_pulse_a: assert property ($fell(we_n) |-> we_low_s ##1 we_n)
    else $error("write strobe not four stable cycles");
  we_strobe_a: assert property (!we_n |-> !ce_n && oe_n && data_oe)
    else $error("write strobe outside a selected write");
  read_gate_a: assert property (!oe_n |-> !ce_n && !data_oe && we_n)
    else $error("output gate while host drives data");
  idle_bus_a: assert property (cmd_ready |-> ce_n && we_n && oe_n && !data_oe)
    else $error("bus active while idle");
  answer_pulse_a: assert property (rsp_valid |-> cmd_ready ##1 !rsp_valid)
    else $error("answer pulse not one cycle");
  mode_hold_a: assert property (cmd_ready && $past(cmd_ready) |-> $stable(mode))
    else $error("mode changed without a command");
  guard_follow_a: assert property (1'b1 |=> wp_n == !$past(boot_protect))
    else $error("boot guard pin wrong");
  reset_long_a: assert property ($rose(flash_rst_n) |-> low_cnt_r >= 8'h31)
    else $error("reset pin pulse too short");
  refuse_quiet_a: assert property (rsp_valid && rsp_err |-> ce_n && $past(ce_n))
    else $error("refused command touched the pins");
  busy_wait_a: assert property (!ready_busy_n |-> we_n)
    else $error("write while device busy");
  lock_sticky_a: assert property (user_locked |=> user_locked)
    else $error("lock state lost");
endmodule
bind fqs_host fqs_props u_props (.*);
`default_nettype wire

// file: bench/fqs_flash_model.sv
// behavioural model of the parallel flash device
`timescale 1ns/1ns
`default_nettype none
module fqs_flash_model
  import fqs_pkg::*;
#(
  parameter logic [15:0] MAKER_ID  = 16'h00a1, // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5a5a, // arbitrary value
  parameter logic [15:0] QRY_WORD  = 16'h0051  // table word at 10h
) (
  input  wire logic                       clk,
  input  wire logic                       ce_n,
  input  wire logic                       oe_n,
  input  wire logic                       we_n,
  input  wire logic [fqs_pkg::ADDR_W-1:0] addr,
  input  wire logic [fqs_pkg::DATA_W-1:0] data_out,
  input  wire logic                       wp_n,
  input  wire logic                       flash_rst_n,
  input  wire logic                       slow,
  output logic      [fqs_pkg::DATA_W-1:0] data_in,
  output logic                            ready_busy_n,
  output logic      [fqs_pkg::ADDR_W-1:0] erase_addr = 20'h00000
);
  logic [15:0] arr [logic [19:0]]; // array words written so far
  logic [15:0] sec [logic [7:0]];  // security words
  fqs_mode_t   md     = MODE_READ;
  int          st     = 0;         // unlock step
  int          busy   = 0;         // cycles of internal work left
  logic        locked = 1'h0;
  logic        tog    = 1'h0;
  logic [15:0] last   = 16'h0000;  // last word driven, for release
  logic [15:0] rd;
  // commands latch on the strobe's rising edge while selected
  always @(posedge we_n) begin
    if (!ce_n && flash_rst_n && busy == 0) begin
      if (st == 0 && addr == QUERY_SHORT_ADDR && data_out == QUERY_SHORT_DATA)
        md = MODE_QUERY;
      else if (st == 0 || st == 6)
        st = (addr == UNLOCK1_ADDR && data_out == UNLOCK1_DATA) ? st + 1 : 0;
      else if (st == 1 || st == 7)
        st = (addr == UNLOCK2_ADDR && data_out == UNLOCK2_DATA) ? st + 1 : 0;
      else if (st == 2) begin
        st = 0;
        case (data_out)
          CMD_QUERY:    md = MODE_QUERY;
          CMD_ID:       md = MODE_ID;
          CMD_SEC:      md = MODE_SEC;
          CMD_EXIT:     md = MODE_READ;
          CMD_PROG:     st = 3;
          CMD_SEC_PROG: st = 4;
          CMD_SEC_LOCK: st = 5;
          CMD_ERASE:    st = 6;
          default:      st = 0;
        endcase
      end else begin
        if (st == 3 && (wp_n || addr < BOOT_BASE)) arr[addr] = data_out;
        // factory words below 8 stay read-only; user words 8..135
        if (st == 4 && !locked && addr[7:0] >= 8'h08 && addr[7:0] < 8'h88)
          sec[addr[7:0]] = data_out;
        if (st == 5 && data_out == LOCK_DATA) locked = 1'h1;
        if (st == 8) erase_addr = addr;
        busy = slow ? 60 : 12;
        st = 0;
      end
    end
  end
  // reset pin, internal timer and memory of the last driven word
  always @(posedge clk) begin
    if (!flash_rst_n) begin
      md = MODE_READ;
      st = 0;
      busy = 0;
    end else if (busy > 0) busy = busy - 1;
    if (!ce_n && !oe_n) last = rd;
  end
  // status bit flips on every read while busy
  always @(negedge oe_n) if (busy > 0) tog = ~tog;
  always @* begin
    case (md)
      MODE_QUERY: rd = (addr == 20'h00010) ? QRY_WORD : 16'h0000;
      MODE_ID:    rd = (addr == 20'h00000) ? MAKER_ID : DEVICE_ID;
      MODE_SEC:   rd = sec.exists(addr[7:0]) ? sec[addr[7:0]] : 16'hffff;
      default:    rd = arr.exists(addr) ? arr[addr] : 16'hffff;
    endcase
    if (busy > 0) rd[TOGGLE_BIT] = tog;
  end
  // released bus shows the inverse of the last word
  assign data_in = (!ce_n && !oe_n) ? rd : ~last;
  assign ready_busy_n = (busy == 0);
endmodule
`default_nettype wire

// file: bench/fqs_host_bench.sv
// self-checking bench of the flash mode controller
`timescale 1ns/1ns
`default_nettype none
module fqs_host_bench
  import fqs_pkg::*;
;
  typedef struct {
    fqs_op_t op; logic [19:0] a; logic [15:0] d;
    logic e; logic [15:0] x; fqs_mode_t m;
  } fqs_row_t;
  logic clk = 1'h0, reset = 1'h1, cmd_valid = 1'h0;
  logic boot_protect = 1'h0, slow = 1'h0;
  fqs_op_t cmd_op = OP_READ;
  logic [19:0] cmd_addr = 20'h0, addr, erase_addr;
  logic [15:0] cmd_data = 16'h0, rsp_data, data_out, data_in;
  logic cmd_ready, rsp_valid, rsp_err, user_locked, ce_n, oe_n, we_n;
  logic data_oe, wp_n, flash_rst_n, ready_busy_n;
  fqs_mode_t mode;
  int failures = 0, checks_done = 0;
  // each row: command, address, data, refused, read word, mode after
  fqs_row_t rows [22] = '{
    '{OP_READ,20'h100,16'h0,1'h0,16'hffff,MODE_READ},
    '{OP_PROGRAM,20'h100,16'h1234,1'h0,16'h0,MODE_READ},
    '{OP_READ,20'h100,16'h0,1'h0,16'h1234,MODE_READ},
    '{OP_QUERY_ENTER,20'h0,16'h0,1'h0,16'h0,MODE_QUERY},
    '{OP_READ,20'h10,16'h0,1'h0,16'h51,MODE_QUERY},
    '{OP_ID_ENTER,20'h0,16'h0,1'h1,16'h0,MODE_QUERY},
    '{OP_PROGRAM,20'h100,16'h1,1'h1,16'h0,MODE_QUERY},
    '{OP_EXIT,20'h0,16'h0,1'h0,16'h0,MODE_READ},
    '{OP_QUERY_SHORT,20'h0,16'h0,1'h0,16'h0,MODE_QUERY},
    '{OP_HW_RESET,20'h0,16'h0,1'h0,16'h0,MODE_READ},
    '{OP_ID_ENTER,20'h0,16'h0,1'h0,16'h0,MODE_ID},
    '{OP_READ,20'h0,16'h0,1'h0,16'ha1,MODE_ID},
    '{OP_READ,20'h1,16'h0,1'h0,16'h5a5a,MODE_ID},
    '{OP_EXIT,20'h0,16'h0,1'h0,16'h0,MODE_READ},
    '{OP_SEC_PROGRAM,20'h10,16'habcd,1'h0,16'h0,MODE_READ},
    '{OP_SEC_ENTER,20'h0,16'h0,1'h0,16'h0,MODE_SEC},
    '{OP_READ,20'h10,16'h0,1'h0,16'habcd,MODE_SEC},
    '{OP_EXIT,20'h0,16'h0,1'h0,16'h0,MODE_READ},
    '{OP_READ,20'h10,16'h0,1'h0,16'hffff,MODE_READ},
    '{OP_SEC_LOCK,20'h0,16'h0,1'h0,16'h0,MODE_READ},
    '{OP_SEC_PROGRAM,20'h12,16'h5555,1'h1,16'h0,MODE_READ},
    '{OP_BLOCK_ERASE,20'h23,16'h0,1'h1,16'h0,MODE_READ}};
  fqs_host dut (.*);
  fqs_flash_model dev (.*);
  always #5 clk = ~clk;
  task automatic chk(input logic [19:0] s, input logic [19:0] x);
    checks_done++;
    if (s !== x) begin
      failures++;
      $display("Error %0t: got %h want %h", $time, s, x);
    end
  endtask
  // one command: wait for taking, then for the answer
  task automatic run(input fqs_op_t o, input logic [19:0] a,
                     input logic [15:0] d);
    cmd_op <= o;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_valid <= 1'h1;
    do @(posedge clk); while (cmd_ready !== 1'h1);
    cmd_valid <= 1'h0;
    do @(posedge clk); while (rsp_valid !== 1'h1);
    @(posedge clk);
  endtask
  // pins idle, reset pin low, in reset and just after it
  task automatic do_reset;
    reset <= 1'h1;
    repeat (5) @(posedge clk);
    chk({17'h0, ce_n, flash_rst_n, cmd_ready}, 20'h4);
    reset <= 1'h0;
    repeat (10) @(posedge clk);
    chk({17'h0, ce_n, flash_rst_n, cmd_ready}, 20'h4);
  endtask
  task automatic conclude;
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #900000;
    failures++;
    conclude();
  end
  initial begin
    do_reset();
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].a, rows[i].d);
      chk({19'h0, rsp_err}, {19'h0, rows[i].e});
      chk({18'h0, mode}, {18'h0, rows[i].m});
      if (rows[i].op == OP_READ)
        chk({4'h0, rsp_data}, {4'h0, rows[i].x});
    end
    chk({19'h0, user_locked}, 20'h1);
    run(OP_SECTOR_ERASE, 20'h12345, 16'h0);
    chk(erase_addr, 20'h12000);
    run(OP_BLOCK_ERASE, 20'h21, 16'h0);
    chk(erase_addr, 20'hfd000);
    run(OP_BLOCK_ERASE, 20'h1f, 16'h0);
    chk(erase_addr, 20'hf8000);
    run(OP_BLOCK_ERASE, 20'h3, 16'h0);
    chk(erase_addr, 20'h18000);
    boot_protect <= 1'h1;
    repeat (3) @(posedge clk);
    run(OP_PROGRAM, 20'hfe010, 16'h77);
    chk({19'h0, rsp_err}, 20'h1);
    boot_protect <= 1'h0;
    slow <= 1'h1;
    repeat (3) @(posedge clk);
    run(OP_PROGRAM, 20'hfe010, 16'h77);
    run(OP_READ, 20'hfe010, 16'h0);
    chk({4'h0, rsp_data}, 20'h77);
    run(OP_QUERY_ENTER, 20'h0, 16'h0);
    do_reset();
    run(OP_READ, 20'h100, 16'h0);
    chk({2'h0, mode, rsp_data}, 20'h1234);
    conclude();
  end
endmodule
`default_nettype wire
